/* hbil_rx_sampler.sv */
// Shared constants and the receive pin sampler of the host bus interrupt logic
`default_nettype none

package hbil_pkg;
  // Register indexes on the host bus (one word each)
  localparam logic [3:0] IDX_CONFIG = 4'h0;
  localparam logic [3:0] IDX_TX_CTRL = 4'h1;
  localparam logic [3:0] IDX_TX_STAT = 4'h2;
  localparam logic [3:0] IDX_DATA = 4'h3;
  localparam logic [3:0] IDX_RX_CTRL = 4'h5;
  localparam logic [3:0] IDX_RX_SLOT = 4'h8;
  localparam logic [3:0] IDX_EDGE = 4'h9;
  localparam logic [3:0] IDX_RX_MODE = 4'hB;
  localparam logic [3:0] IDX_ALT_LAST = 4'hD;
  localparam logic [3:0] IDX_MASK = 4'hE;
  localparam logic [3:0] IDX_STATUS = 4'hF;
  // Storage slots: 0..15 foreground, 16..18 alternate bank
  localparam int NUM_SLOTS = 19;
  localparam logic [4:0] SLOT_ALT_BASE = 5'h10;
  localparam logic [4:0] SLOT_ALT_FIRST = 5'h10;
  // Configuration register fields
  localparam int CFG_DYN_BIT = 0;
  localparam int CFG_POL_BIT = 1;
  localparam int CFG_BM_BIT = 3;
  localparam int CFG_BANK_BIT = 4;
  localparam int CFG_TRANSP_BIT = 5;
  // Other control fields
  localparam int RXC_PIN_FN_BIT = 6;
  localparam int RXS_INPUT_SEL_BIT = 7;
  localparam int EDGE_RX_BIT = 0;
  localparam int RXM_INVERT_BIT = 7;
  localparam int ALT1_START_BIT = 3;
  localparam int TXS_LIVE_BIT = 7;
  localparam int LEVEL_W = 6;
  localparam int COUNT_W = 7;
  // Interrupt status bit positions
  localparam int FLAG_W = 7;
  localparam int ST_TX_DONE = 0;
  localparam int ST_TX_SPACE = 1;
  localparam int ST_UNDERRUN = 2;
  localparam int ST_RX_FILL = 3;
  localparam int ST_FRAME_END = 4;
  localparam int ST_OVERRUN = 5;
  localparam int ST_IDLE = 6;
  // Values after reset
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_EDGE = 8'h01;
  localparam logic RST_IRQ_PIN = 1'b1;
endpackage

module hbil_rx_sampler (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic pin_function_i,
  input wire logic input_select_i,
  input wire logic edge_rising_i,
  input wire logic invert_i,
  input wire logic rx_shared_pin_i,
  input wire logic receive_data_first_i,
  input wire logic transmit_clock_in_i,
  output logic rx_bit_o,
  output logic rx_bit_valid_o
);
  typedef struct packed {
    logic clk_d;
    logic bit_v;
    logic valid;
  } hbil_smp_state_type;

  hbil_smp_state_type state_r, state_nxt;
  logic clk_sel, edge_hit, data_sel;

  // Clock source and data input selection
  always_comb begin
    clk_sel = pin_function_i ? transmit_clock_in_i : rx_shared_pin_i;
    data_sel = (pin_function_i && input_select_i) ? rx_shared_pin_i
                                                  : receive_data_first_i;
    edge_hit = edge_rising_i ? (clk_sel && !state_r.clk_d)
                             : (!clk_sel && state_r.clk_d);
    state_nxt = state_r;
    state_nxt.clk_d = clk_sel;
    state_nxt.valid = edge_hit;
    if (edge_hit) begin
      state_nxt.bit_v = data_sel ^ invert_i;
    end
  end

  // Sampling works only while the serial clock stays under half our rate
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rx_bit_o = state_r.bit_v;
  assign rx_bit_valid_o = state_r.valid;

  property p_rise_edge;
    @(posedge clock_i) disable iff (sys_rst_i)
      (edge_rising_i && !pin_function_i && rx_shared_pin_i && !state_r.clk_d)
      |=> rx_bit_valid_o;
  endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("missed receive clock edge");

  property p_pin_function;
    @(posedge clock_i) disable iff (sys_rst_i)
      (pin_function_i && input_select_i && !invert_i && edge_hit)
      |=> (rx_bit_o == $past(rx_shared_pin_i));
  endproperty
  a_pin_function: assert property (p_pin_function) else $error("second input not taken");
endmodule

`default_nettype wire

/* hbil_top.sv */
// Host register interface and interrupt logic of the serial controller
//
// Contract
// - Shared pin is receive clock when pin function bit 0, second data when 1.
// - Rising receive edge after reset; falling when edge select cleared.
// - Second-data mode clocks from transmit clock; input select 1 picks second data.
// - Nineteen registers reached through sixteen host locations.
// - Address taken from the four low lines plus line six; lines four and five must be low.
// - Bank select 1 maps indexes 11 to 13 onto the alternate registers.
// - Interrupt output active level follows the polarity bit.
// - Status records every condition; masked ones never move the output.
// - Output asserts on first unmasked condition, holds until status read.
// - Condition during status read gives deassert then reassert.
// - Masking sole active condition deasserts; unmasking active one asserts.
// - Nondynamic mode: status read clears; condition must recur to flag again.
// - Dynamic mode: space and fill flags clear only when remedied.
// - Live space copy in transmit status tracks condition, no interrupt.
// - Transparent mode disables frame end, idle, underrun; done flags underrun.
// - Polled start bit in first alternate register; fill level one interrupts on start.
// - Space flag sets when free room covers the trigger level.
// - Fill flag sets when receive buffer reaches the fill level.
`default_nettype none

module hbil_top (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Avalon-MM slave
  input wire logic [6:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [7:0] avs_writedata_i,
  output logic [7:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_pin_o,
  // Buffer levels and event pulses from the data path
  input wire logic [hbil_pkg::COUNT_W-1:0] tx_free_count_i,
  input wire logic [hbil_pkg::COUNT_W-1:0] rx_count_i,
  input wire logic tx_done_evt_i,
  input wire logic tx_underrun_evt_i,
  input wire logic rx_frame_end_evt_i,
  input wire logic rx_overrun_evt_i,
  input wire logic rx_idle_evt_i,
  input wire logic rx_start_evt_i,
  // Serial receive pins
  input wire logic rx_shared_pin_i,
  input wire logic receive_data_first_i,
  input wire logic transmit_clock_in_i,
  output logic rx_bit_o,
  output logic rx_bit_valid_o
);
  import hbil_pkg::*;

  typedef struct packed {
    logic [NUM_SLOTS-1:0][7:0] regs;
    logic waitreq;
    logic [7:0] rdata;
    logic [4:0] slot;
    logic slot_ok;
    logic [FLAG_W-1:0] flags;
    logic rx_start;
    logic tx_cond_d;
    logic rx_cond_d;
    logic irq_pin;
  } hbil_state_type;

  hbil_state_type state_r, state_nxt;

  // Map a bus address to a storage slot; bit 6 is the block move window
  function automatic logic [5:0] hbil_decode(input logic [6:0] addr,
                                             input logic bank, input logic bm);
    logic [4:0] idx;
    logic ok;
    idx = {1'b0, addr[3:0]};
    ok = 1'b1;
    if (addr[6]) begin
      idx = {1'b0, IDX_DATA};
      ok = bm;
    end else if (bank && addr[3:0] >= IDX_RX_MODE && addr[3:0] <= IDX_ALT_LAST) begin
      idx = SLOT_ALT_BASE + {1'b0, addr[3:0] - IDX_RX_MODE};
    end
    if (addr[5:4] != 2'h0) begin
      ok = 1'b0;
    end
    return {ok, idx};
  endfunction

  logic cfg_dyn, cfg_pol, cfg_bank, cfg_bm, cfg_transp;
  logic tx_cond, rx_cond, access, req_new, done, rd_status, rd_alt1;
  logic [FLAG_W-1:0] ev, clr, mask, dyn_keep;
  logic [5:0] dec;
  logic gated, late_evt;

  // Configuration fields
  assign cfg_dyn = state_r.regs[IDX_CONFIG][CFG_DYN_BIT];
  assign cfg_pol = state_r.regs[IDX_CONFIG][CFG_POL_BIT];
  assign cfg_bm = state_r.regs[IDX_CONFIG][CFG_BM_BIT];
  assign cfg_bank = state_r.regs[IDX_CONFIG][CFG_BANK_BIT];
  assign cfg_transp = state_r.regs[IDX_CONFIG][CFG_TRANSP_BIT];
  assign mask = state_r.regs[IDX_MASK][FLAG_W-1:0];

  // Level conditions from the buffers
  assign tx_cond = tx_free_count_i >= {1'b0, state_r.regs[IDX_TX_CTRL][LEVEL_W-1:0]};
  assign rx_cond = rx_count_i >= {1'b0, state_r.regs[IDX_RX_CTRL][LEVEL_W-1:0]};

  // Bus handshake terms; one wait cycle per access
  assign access = avs_read_i || avs_write_i;
  assign req_new = access && state_r.waitreq;
  assign done = access && !state_r.waitreq;
  assign dec = hbil_decode(avs_address_i, cfg_bank, cfg_bm);
  assign rd_status = done && avs_read_i && state_r.slot_ok
                     && state_r.slot == {1'b0, IDX_STATUS};
  assign rd_alt1 = done && avs_read_i && state_r.slot_ok && state_r.slot == SLOT_ALT_FIRST;

  // Event vector; transparent mode drops framing events
  always_comb begin
    ev = '0;
    ev[ST_TX_DONE] = tx_done_evt_i || (cfg_transp && tx_underrun_evt_i);
    ev[ST_TX_SPACE] = tx_cond && !state_r.tx_cond_d;
    ev[ST_UNDERRUN] = !cfg_transp && tx_underrun_evt_i;
    ev[ST_RX_FILL] = rx_cond && !state_r.rx_cond_d;
    ev[ST_FRAME_END] = !cfg_transp && rx_frame_end_evt_i;
    ev[ST_OVERRUN] = rx_overrun_evt_i;
    ev[ST_IDLE] = !cfg_transp && rx_idle_evt_i;
  end

  // Level flags held by their conditions in dynamic mode
  always_comb begin
    dyn_keep = '0;
    if (cfg_dyn) begin
      dyn_keep[ST_TX_SPACE] = 1'b1;
      dyn_keep[ST_RX_FILL] = 1'b1;
    end
    clr = rd_status ? ~dyn_keep : '0;
  end

  // Next state
  always_comb begin
    state_nxt = state_r;
    state_nxt.tx_cond_d = tx_cond;
    state_nxt.rx_cond_d = rx_cond;
    // Requests are registered before any register or flag moves
    if (req_new) begin
      state_nxt.waitreq = 1'b0;
      state_nxt.slot = dec[4:0];
      state_nxt.slot_ok = dec[5];
      state_nxt.rdata = 8'h00;
      if (dec[5]) begin
        case (dec[4:0])
          {1'b0, IDX_STATUS}: state_nxt.rdata = {1'b0, state_r.flags};
          {1'b0, IDX_TX_STAT}: state_nxt.rdata = {tx_cond, tx_free_count_i};
          SLOT_ALT_FIRST: begin
            state_nxt.rdata = state_r.regs[SLOT_ALT_FIRST];
            state_nxt.rdata[ALT1_START_BIT] = state_r.rx_start;
          end
          default: state_nxt.rdata = state_r.regs[dec[4:0]];
        endcase
      end
    end
    // Completion edge: write lands, answer released
    if (done) begin
      state_nxt.waitreq = 1'b1;
      if (avs_write_i && state_r.slot_ok && state_r.slot != {1'b0, IDX_STATUS}
          && state_r.slot != {1'b0, IDX_TX_STAT}) begin
        state_nxt.regs[state_r.slot] = avs_writedata_i;
      end
    end
    // Flags record all conditions; the set beats a read clear
    state_nxt.flags = (state_r.flags & ~clr) | ev;
    if (cfg_dyn) begin
      state_nxt.flags[ST_TX_SPACE] = tx_cond;
      state_nxt.flags[ST_RX_FILL] = rx_cond;
    end
    state_nxt.rx_start = (state_r.rx_start && !rd_alt1) || rx_start_evt_i;
    // Gap of one cycle when a new unmasked event meets the clearing read
    late_evt = rd_status && |(ev & mask) && !(|(state_r.flags & mask & dyn_keep));
    gated = |(state_nxt.flags & mask) && !late_evt;
    state_nxt.irq_pin = cfg_pol ? gated : !gated;
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_r <= '0;
      state_r.regs[IDX_EDGE] <= RST_EDGE;
      state_r.waitreq <= 1'b1;
      state_r.irq_pin <= RST_IRQ_PIN;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign avs_readdata_o = state_r.rdata;
  assign avs_waitrequest_o = state_r.waitreq;
  assign irq_pin_o = state_r.irq_pin;

  // Receive pin sampler
  hbil_rx_sampler u_sampler (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .pin_function_i(state_r.regs[IDX_RX_CTRL][RXC_PIN_FN_BIT]),
    .input_select_i(state_r.regs[IDX_RX_SLOT][RXS_INPUT_SEL_BIT]),
    .edge_rising_i(state_r.regs[IDX_EDGE][EDGE_RX_BIT]),
    .invert_i(state_r.regs[IDX_RX_MODE][RXM_INVERT_BIT]),
    .rx_shared_pin_i(rx_shared_pin_i),
    .receive_data_first_i(receive_data_first_i),
    .transmit_clock_in_i(transmit_clock_in_i),
    .rx_bit_o(rx_bit_o),
    .rx_bit_valid_o(rx_bit_valid_o)
  );

  property p_answer;
    @(posedge clock_i) disable iff (sys_rst_i)
      (access && avs_waitrequest_o) |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_answer: assert property (p_answer) else $error("answer not in one cycle");

  property p_read_clear;
    @(posedge clock_i) disable iff (sys_rst_i)
      (rd_status && !cfg_dyn && ev == '0) |=> (state_r.flags == '0);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("status read did not clear");

  property p_record;
    @(posedge clock_i) disable iff (sys_rst_i)
      rx_overrun_evt_i |=> state_r.flags[ST_OVERRUN];
  endproperty
  a_record: assert property (p_record) else $error("condition not recorded");

  property p_hold;
    @(posedge clock_i) disable iff (sys_rst_i)
      (|(state_r.flags & mask & ~dyn_keep) && !rd_status && $stable(cfg_pol) && !done)
      |=> (irq_pin_o == $past(cfg_pol));
  endproperty
  a_hold: assert property (p_hold) else $error("interrupt not held");

  property p_quiet;
    @(posedge clock_i) disable iff (sys_rst_i)
      ((state_r.flags & mask) == '0 && (ev & mask) == '0 && !cfg_dyn && !done)
      |=> (irq_pin_o != $past(cfg_pol));
  endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt with nothing unmasked");

  property p_gap;
    @(posedge clock_i) disable iff (sys_rst_i)
      late_evt |=> (irq_pin_o != $past(cfg_pol)) ##1 (irq_pin_o == $past(cfg_pol, 2));
  endproperty
  a_gap: assert property (p_gap) else $error("no deassert and reassert");

  property p_dyn_hold;
    @(posedge clock_i) disable iff (sys_rst_i)
      (cfg_dyn && tx_cond && mask[ST_TX_SPACE] && !done) |=> (irq_pin_o == $past(cfg_pol));
  endproperty
  a_dyn_hold: assert property (p_dyn_hold) else $error("dynamic flag dropped");

  property p_live;
    @(posedge clock_i) disable iff (sys_rst_i)
      (req_new && dec == {1'b1, 1'b0, IDX_TX_STAT})
      |=> (avs_readdata_o[TXS_LIVE_BIT] == $past(tx_cond));
  endproperty
  a_live: assert property (p_live) else $error("live space bit wrong");

  property p_transp;
    @(posedge clock_i) disable iff (sys_rst_i)
      (cfg_transp && !state_r.flags[ST_FRAME_END]) |=> !state_r.flags[ST_FRAME_END];
  endproperty
  a_transp: assert property (p_transp) else $error("frame end in transparent mode");
endmodule

`default_nettype wire

/* hbil_host_model.sv */
// Host processor model: Avalon-MM master for the register interface
`default_nettype none
module hbil_host_model (
  input wire logic clock_i,
  output logic [6:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [7:0] writedata_o,
  input wire logic [7:0] readdata_i,
  input wire logic waitrequest_i,
  output logic timeout_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    address_o = 7'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 8'h00;
    timeout_o = 1'b0;
  end
  // One transfer; request held until waitrequest is sampled low
  task automatic access(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
    int n;
    n = 0;
    @(posedge clock_i);
    address_o <= addr;
    writedata_o <= wdata;
    write_o <= wr;
    read_o <= ~wr;
    // Pre-edge value is what this edge samples
    do begin
      @(posedge clock_i);
      n++;
    end while (waitrequest_i !== 1'b0 && n < 50);
    rdata = readdata_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
    if (n >= 50) timeout_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* hbil_top_test.sv */
// Self-checking bench for the host bus interrupt logic
`default_nettype none
module hbil_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import hbil_pkg::*;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [6:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [7:0] avs_writedata_i;
  logic [7:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic irq_pin_o;
  logic [COUNT_W-1:0] tx_free_count_i = 7'h05;
  logic [COUNT_W-1:0] rx_count_i = 7'h00;
  logic [5:0] evt = 6'h00;
  logic rx_shared_pin_i = 1'b0;
  logic receive_data_first_i = 1'b1;
  logic transmit_clock_in_i = 1'b0;
  logic rx_bit_o;
  logic rx_bit_valid_o;
  logic host_to;
  logic [7:0] d;
  logic seen;
  int n_fail;
  int checked;

  hbil_top hbil_top_inst (.clock_i, .sys_rst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .irq_pin_o,
    .tx_free_count_i, .rx_count_i, .tx_done_evt_i(evt[0]), .tx_underrun_evt_i(evt[1]),
    .rx_frame_end_evt_i(evt[2]), .rx_overrun_evt_i(evt[3]), .rx_idle_evt_i(evt[4]),
    .rx_start_evt_i(evt[5]), .rx_shared_pin_i, .receive_data_first_i,
    .transmit_clock_in_i, .rx_bit_o, .rx_bit_valid_o);
  hbil_host_model host_inst (.clock_i, .address_o(avs_address_i), .read_o(avs_read_i),
    .write_o(avs_write_i), .writedata_o(avs_writedata_i), .readdata_i(avs_readdata_o),
    .waitrequest_i(avs_waitrequest_o), .timeout_o(host_to));

  // 100 MHz clock
  initial begin
    forever #5 clock_i = ~clock_i;
  end

  task automatic summarize;
    if (n_fail == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // A stuck bus ends the run at once
  always @(posedge host_to) begin
    n_fail++;
    summarize();
  end
  // Comparisons: byte values and single pins
  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk1(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] x;
    host_inst.access(1'b1, a, v, x);
  endtask
  task automatic rd(input logic [6:0] a, input string name, input logic [7:0] exp);
    logic [7:0] x;
    host_inst.access(1'b0, a, 8'h00, x);
    chk8(name, exp, x);
  endtask
  // One-cycle event pulse, then time for flag and pin to settle
  task automatic pulse(input int i);
    @(posedge clock_i);
    evt <= 6'h01 << i;
    @(posedge clock_i);
    evt <= 6'h00;
    cyc(3);
  endtask
  // Pin levels held five cycles, well under half the master rate
  task automatic serial(input logic sh, input logic txc, input logic [1:0] exp);
    logic [1:0] got;
    got = 2'b00;
    @(posedge clock_i);
    rx_shared_pin_i <= sh;
    transmit_clock_in_i <= txc;
    repeat (4) begin
      @(posedge clock_i);
      if (rx_bit_valid_o === 1'b1) got = {1'b1, rx_bit_o};
    end
    chk8("serial", {6'h00, exp}, {6'h00, got});
  endtask

  // Main sequence
  initial begin
    n_fail = 0;
    checked = 0;
    cyc(6);
    sys_rst_i <= 1'b0;
    cyc(1);
    chk1("irq idle", 1'b1, irq_pin_o);
    rd(7'h09, "edge reset", 8'h01);
    rd(7'h00, "config reset", 8'h00);
    wr(7'h04, 8'h3C);
    rd(7'h04, "storage", 8'h3C);
    rd(7'h14, "unmapped", 8'h00);
    rd(7'h40, "window off", 8'h00);
    wr(7'h00, 8'h08);
    wr(7'h40, 8'h99);
    rd(7'h03, "window on", 8'h99);
    wr(7'h0C, 8'hA5);
    wr(7'h00, 8'h10);
    wr(7'h0C, 8'h5A);
    rd(7'h0C, "alt reg", 8'h5A);
    wr(7'h00, 8'h00);
    rd(7'h0C, "fg reg", 8'hA5);
    wr(7'h01, 8'h0A);
    wr(7'h05, 8'h0A);
    host_inst.access(1'b0, 7'h0F, 8'h00, d);
    rd(7'h0F, "status clear", 8'h00);
    pulse(0);
    chk1("masked pin", 1'b1, irq_pin_o);
    rd(7'h0F, "masked status", 8'h01);
    rd(7'h0F, "read clears", 8'h00);
    wr(7'h0E, 8'h7F);
    pulse(0);
    chk1("pin asserted", 1'b0, irq_pin_o);
    pulse(3);
    chk1("pin held", 1'b0, irq_pin_o);
    rd(7'h0F, "two flags", 8'h21);
    cyc(3);
    chk1("pin released", 1'b1, irq_pin_o);
    pulse(0);
    wr(7'h0E, 8'h00);
    cyc(3);
    chk1("mask drops", 1'b1, irq_pin_o);
    wr(7'h0E, 8'h01);
    cyc(3);
    chk1("unmask raises", 1'b0, irq_pin_o);
    // Event lands in the completing cycle of a status read
    fork
      host_inst.access(1'b0, 7'h0F, 8'h00, d);
      begin
        cyc(2);
        evt <= 6'h01;
        @(posedge clock_i);
        evt <= 6'h00;
      end
    join
    seen = 1'b0;
    repeat (6) begin
      @(posedge clock_i);
      if (irq_pin_o === 1'b1) seen = 1'b1;
    end
    chk1("gap", 1'b1, seen);
    chk1("reassert", 1'b0, irq_pin_o);
    rd(7'h0F, "late flag", 8'h01);
    wr(7'h00, 8'h02);
    cyc(3);
    chk1("pol idle", 1'b0, irq_pin_o);
    pulse(0);
    chk1("pol active", 1'b1, irq_pin_o);
    rd(7'h0F, "pol status", 8'h01);
    wr(7'h00, 8'h01);
    wr(7'h0E, 8'h02);
    @(posedge clock_i);
    tx_free_count_i <= 7'h0A;
    cyc(3);
    chk1("space pin", 1'b0, irq_pin_o);
    rd(7'h0F, "space flag", 8'h02);
    rd(7'h0F, "space held", 8'h02);
    rd(7'h02, "live copy", 8'h8A);
    @(posedge clock_i);
    tx_free_count_i <= 7'h09;
    cyc(3);
    rd(7'h0F, "space gone", 8'h00);
    chk1("space pin off", 1'b1, irq_pin_o);
    rd(7'h02, "live off", 8'h09);
    wr(7'h00, 8'h00);
    wr(7'h0E, 8'h08);
    @(posedge clock_i);
    rx_count_i <= 7'h0A;
    cyc(3);
    chk1("fill pin", 1'b0, irq_pin_o);
    rd(7'h0F, "fill flag", 8'h08);
    rd(7'h0F, "fill once", 8'h00);
    // Fill level of one byte turns the first received byte into an interrupt
    @(posedge clock_i);
    rx_count_i <= 7'h00;
    wr(7'h05, 8'h01);
    @(posedge clock_i);
    rx_count_i <= 7'h01;
    cyc(3);
    chk1("start irq", 1'b0, irq_pin_o);
    rd(7'h0F, "start fill", 8'h08);
    wr(7'h00, 8'h20);
    wr(7'h0E, 8'h00);
    pulse(1);
    pulse(2);
    pulse(4);
    rd(7'h0F, "transparent", 8'h01);
    wr(7'h00, 8'h10);
    pulse(5);
    rd(7'h0B, "start bit", 8'h08);
    rd(7'h0B, "start clear", 8'h00);
    wr(7'h00, 8'h00);
    serial(1'b1, 1'b0, 2'b11);
    serial(1'b0, 1'b0, 2'b00);
    wr(7'h09, 8'h00);
    serial(1'b1, 1'b0, 2'b00);
    serial(1'b0, 1'b0, 2'b11);
    wr(7'h05, 8'h4A);
    serial(1'b0, 1'b1, 2'b00);
    serial(1'b0, 1'b0, 2'b11);
    wr(7'h08, 8'h80);
    serial(1'b0, 1'b1, 2'b00);
    serial(1'b0, 1'b0, 2'b10);
    summarize();
  end
endmodule
`default_nettype wire
